// File: logic/vic_pkg.sv
`default_nettype none
package vic_pkg;

	localparam int          NUM_IRQ_DEF      = 114;
	localparam int          NUM_TRAP         = 7;
	localparam int          VEC_OFFSET       = 8;
	localparam int          TRAP_VEC_FIRST   = 1;
	localparam logic [23:0] TABLE_BASE       = 24'h000004;
	localparam logic [23:0] RESET_ADDR       = 24'h000000;
	localparam logic [3:0]  ENTRY_CYCLES     = 4'h4;
	localparam logic [3:0]  RETURN_CYCLES    = 4'h3;
	localparam logic [3:0]  TRAP_TOP_LEVEL   = 4'hF;

	////////////////////////////////////////////////////////////////////////
	localparam logic [11:0] OFF_FLAG         = 12'h000;
	localparam logic [11:0] OFF_ENABLE       = 12'h040;
	localparam logic [11:0] OFF_PRIO         = 12'h080;
	localparam logic [11:0] OFF_CPU_IPL      = 12'h100;
	localparam logic [11:0] OFF_PENDING      = 12'h104;
	localparam logic [11:0] OFF_IRQ_STATUS   = 12'h108;
	localparam logic [11:0] OFF_IRQ_MASK     = 12'h10C;
	localparam int          PEND_VEC_POS     = 0;
	localparam int          PEND_LEVEL_POS   = 8;
	localparam int          IPL_RW_BITS      = 3;
	localparam int          PRIO_FIELD_STEP  = 4;
	localparam logic [3:0]  IPL_RESET        = 4'h0;
	localparam logic [1:0]  STAT_RESET       = 2'h0;
	localparam int          STAT_ENTRY       = 0;
	localparam int          STAT_RETURN      = 1;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic        valid;
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} vic_wreq_t;

	typedef struct packed {
		logic        valid;
		logic [6:0]  vector;
		logic [3:0]  level;
		logic [23:0] addr;
	} vic_cpu_req_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ENTRY   = 4'h2,
		ST_SERVICE = 4'h4,
		ST_RETURN  = 4'h8
	} vic_state_t;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] table_addr(input logic [6:0] vec);
		table_addr = TABLE_BASE + {16'h0000, vec, 1'b0};
	endfunction

	// Reserved request numbers carry no bits at all
	function automatic logic is_impl(input int irq);
		is_impl = (irq <= 14) || (irq >= 16 && irq <= 20) || (irq >= 24 && irq <= 38)
			|| (irq == 49) || (irq == 50) || (irq >= 57 && irq <= 58)
			|| (irq >= 65 && irq <= 67) || (irq == 70) || (irq == 77)
			|| (irq >= 94 && irq <= 96);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old_v,
			input logic [31:0] wdata, input logic [3:0] strb);
		merge16 = {strb[1] ? wdata[15:8] : old_v[15:8], strb[0] ? wdata[7:0] : old_v[7:0]};
	endfunction

endpackage
`default_nettype wire

// File: logic/vic_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module vic_axil_slave (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [11:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [11:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output vic_pkg::vic_wreq_t       wr_req,
	input  wire logic                wr_err,
	output logic [11:0]              rd_addr,
	input  wire logic [31:0]         rd_data,
	input  wire logic                rd_err
);
	import vic_pkg::*;

	logic        aw_held, next_aw_held, w_held, next_w_held;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        wr_fire, rd_fire;

	// Address and data are taken in either order and held until both are in
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rd_addr       = s_axi_araddr;
	assign wr_req        = '{valid: wr_fire, addr: aw_addr, data: w_data, strb: w_strb};

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rresp   = s_axi_rresp;
		next_rdata   = s_axi_rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rdata  = rd_data;
			next_rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			aw_addr      <= 12'h000;
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
		end else begin
			aw_held      <= next_aw_held;
			aw_addr      <= next_aw_addr;
			w_held       <= next_w_held;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// File: logic/vic_resolver.sv
`timescale 1ns/1ps
`default_nettype none
module vic_resolver #(
	parameter int NUM_IRQ = vic_pkg::NUM_IRQ_DEF
) (
	input  wire logic [NUM_IRQ-1:0]        flag,
	input  wire logic [NUM_IRQ-1:0]        enable,
	input  wire logic [NUM_IRQ-1:0][2:0]   prio,
	input  wire logic [vic_pkg::NUM_TRAP-1:0] trap_flag,
	input  wire logic [3:0]                cpu_priority_level,
	output vic_pkg::vic_cpu_req_t          best
);
	import vic_pkg::*;

	always_comb begin
		best = '{valid: 1'b0, vector: 7'h00, level: 4'h0, addr: RESET_ADDR};
		// Ascending scan with strict compare keeps the lowest vector on a tie
		for (int k = 0; k < NUM_TRAP; k++) begin
			if (trap_flag[k] && (!best.valid || 4'(TRAP_TOP_LEVEL - 4'(k)) > best.level)) begin
				best.valid  = 1'b1;
				best.vector = 7'(TRAP_VEC_FIRST + k);
				best.level  = 4'(TRAP_TOP_LEVEL - 4'(k));
			end
		end
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (is_impl(i) && flag[i] && enable[i] && ({1'b0, prio[i]} > cpu_priority_level)
					&& (!best.valid || {1'b0, prio[i]} > best.level)) begin
				best.valid  = 1'b1;
				best.vector = 7'(i + VEC_OFFSET);
				best.level  = {1'b0, prio[i]};
			end
		end
		best.addr = table_addr(best.vector);
	end

endmodule
`default_nettype wire

// File: logic/vic_top.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vic_top #(
	parameter int NUM_IRQ = vic_pkg::NUM_IRQ_DEF
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [11:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [11:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [NUM_IRQ-1:0]        src_req,
	input  wire logic                      ext_irq_0,
	input  wire logic [vic_pkg::NUM_TRAP-1:0] trap_req,
	input  wire logic                      cpu_ack,
	input  wire logic                      cpu_return,
	output vic_pkg::vic_cpu_req_t          cpu_req,
	output logic                           fetch_valid,
	output logic [23:0]                    fetch_addr,
	output logic                           return_done,
	output logic                           irq
);
	import vic_pkg::*;

	localparam int FLAG_WORDS = (NUM_IRQ + 15) / 16;
	localparam int PRIO_WORDS = (NUM_IRQ + 3) / 4;

	////////////////////////////////////////////////////////////////////////
	vic_wreq_t                  wr_req;
	logic                       wr_err;
	logic [11:0]                rd_addr;
	logic [31:0]                rd_data;
	logic                       rd_err;
	logic [NUM_IRQ-1:0]         flag, next_flag, enable, next_enable;
	logic [NUM_IRQ-1:0][2:0]    prio, next_prio;
	logic [NUM_TRAP-1:0]        trap_flag, next_trap_flag;
	logic [3:0]                 cpu_priority_level, next_ipl, saved_ipl, next_saved_ipl;
	logic [6:0]                 pend_vec, next_pend_vec;
	logic [3:0]                 pend_level, next_pend_level;
	logic [1:0]                 stat, next_stat, mask, next_mask;
	vic_state_t                 state, next_state;
	logic [3:0]                 cnt, next_cnt;
	logic                       next_fetch_valid, next_return_done;
	logic [23:0]                next_fetch_addr;
	logic                       ext_meta, ext_sync, ext_prev;
	vic_cpu_req_t               best;
	logic [NUM_IRQ-1:0]         set_vec;
	logic                       take;

	////////////////////////////////////////////////////////////////////////
	vic_axil_slave u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_req        (wr_req),
		.wr_err        (wr_err),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	vic_resolver #(.NUM_IRQ(NUM_IRQ)) u_res (
		.flag      (flag),
		.enable    (enable),
		.prio      (prio),
		.trap_flag (trap_flag),
		.cpu_priority_level       (cpu_priority_level),
		.best      (best)
	);

	////////////////////////////////////////////////////////////////////////
	// Address classification shared by the read and write paths
	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a >= OFF_FLAG && a < OFF_FLAG + 12'(4 * FLAG_WORDS))
			|| (a >= OFF_ENABLE && a < OFF_ENABLE + 12'(4 * FLAG_WORDS))
			|| (a >= OFF_PRIO && a < OFF_PRIO + 12'(4 * PRIO_WORDS))
			|| (a == OFF_CPU_IPL) || (a == OFF_PENDING)
			|| (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK);
	endfunction

	assign wr_err = !addr_ok(wr_req.addr);
	assign rd_err = !addr_ok(rd_addr);

	always_comb begin
		int widx;
		widx = 0;
		rd_data = 32'h00000000;
		if (rd_addr >= OFF_FLAG && rd_addr < OFF_FLAG + 12'(4 * FLAG_WORDS)) begin
			widx = int'((rd_addr - OFF_FLAG) >> 2);
			for (int i = 0; i < NUM_IRQ; i++) begin
				if (i / 16 == widx) rd_data[i % 16] = flag[i] & is_impl(i);
			end
		end else if (rd_addr >= OFF_ENABLE && rd_addr < OFF_ENABLE + 12'(4 * FLAG_WORDS)) begin
			widx = int'((rd_addr - OFF_ENABLE) >> 2);
			for (int i = 0; i < NUM_IRQ; i++) begin
				if (i / 16 == widx) rd_data[i % 16] = enable[i] & is_impl(i);
			end
		end else if (rd_addr >= OFF_PRIO && rd_addr < OFF_PRIO + 12'(4 * PRIO_WORDS)) begin
			widx = int'((rd_addr - OFF_PRIO) >> 2);
			for (int i = 0; i < NUM_IRQ; i++) begin
				if (i / 4 == widx && is_impl(i)) begin
					rd_data[(i % 4) * PRIO_FIELD_STEP +: 3] = prio[i];
				end
			end
		end else if (rd_addr == OFF_CPU_IPL) begin
			rd_data[3:0] = cpu_priority_level;
		end else if (rd_addr == OFF_PENDING) begin
			rd_data[PEND_VEC_POS +: 7]   = pend_vec;
			rd_data[PEND_LEVEL_POS +: 4] = pend_level;
		end else if (rd_addr == OFF_IRQ_STATUS) begin
			rd_data[1:0] = stat;
		end else if (rd_addr == OFF_IRQ_MASK) begin
			rd_data[1:0] = mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin input: second stage feeds the edge detector, never the first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= ext_irq_0;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	always_comb begin
		set_vec    = src_req;
		set_vec[0] = src_req[0] | (ext_sync & ~ext_prev);
	end

	assign take = (state == ST_IDLE) && best.valid && cpu_ack;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [15:0] m;
		int          widx;
		m                = 16'h0000;
		widx             = 0;
		next_flag        = flag;
		next_enable      = enable;
		next_prio        = prio;
		next_ipl         = cpu_priority_level;
		next_mask        = mask;
		next_stat        = stat;
		next_trap_flag   = trap_flag;
		next_saved_ipl   = saved_ipl;
		next_pend_vec    = pend_vec;
		next_pend_level  = pend_level;
		next_state       = state;
		next_cnt         = cnt;
		next_fetch_valid = 1'b0;
		next_return_done = 1'b0;
		next_fetch_addr  = fetch_addr;
		if (wr_req.valid) begin
			if (wr_req.addr >= OFF_FLAG && wr_req.addr < OFF_FLAG + 12'(4 * FLAG_WORDS)) begin
				widx = int'((wr_req.addr - OFF_FLAG) >> 2);
				for (int b = 0; b < 16; b++) begin
					if (widx * 16 + b < NUM_IRQ) m[b] = flag[widx * 16 + b];
				end
				m = merge16(m, wr_req.data, wr_req.strb);
				for (int i = 0; i < NUM_IRQ; i++) begin
					if (i / 16 == widx) next_flag[i] = m[i % 16];
				end
			end else if (wr_req.addr >= OFF_ENABLE
					&& wr_req.addr < OFF_ENABLE + 12'(4 * FLAG_WORDS)) begin
				widx = int'((wr_req.addr - OFF_ENABLE) >> 2);
				for (int b = 0; b < 16; b++) begin
					if (widx * 16 + b < NUM_IRQ) m[b] = enable[widx * 16 + b];
				end
				m = merge16(m, wr_req.data, wr_req.strb);
				for (int i = 0; i < NUM_IRQ; i++) begin
					if (i / 16 == widx) next_enable[i] = m[i % 16];
				end
			end else if (wr_req.addr >= OFF_PRIO && wr_req.addr < OFF_PRIO + 12'(4 * PRIO_WORDS)) begin
				widx = int'((wr_req.addr - OFF_PRIO) >> 2);
				for (int i = 0; i < NUM_IRQ; i++) begin
					if (i / 4 == widx) m[(i % 4) * PRIO_FIELD_STEP +: 3] = prio[i];
				end
				m = merge16(m, wr_req.data, wr_req.strb);
				for (int i = 0; i < NUM_IRQ; i++) begin
					if (i / 4 == widx) next_prio[i] = m[(i % 4) * PRIO_FIELD_STEP +: 3];
				end
			end else if (wr_req.addr == OFF_CPU_IPL) begin
				if (wr_req.strb[0]) next_ipl[IPL_RW_BITS-1:0] = wr_req.data[IPL_RW_BITS-1:0];
			end else if (wr_req.addr == OFF_IRQ_STATUS) begin
				if (wr_req.strb[0]) next_stat = stat & ~wr_req.data[1:0];
			end else if (wr_req.addr == OFF_IRQ_MASK) begin
				if (wr_req.strb[0]) next_mask = wr_req.data[1:0];
			end
		end
		// Source events win over a software clear in the same cycle
		next_flag = next_flag | set_vec;
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (!is_impl(i)) begin
				next_flag[i]   = 1'b0;
				next_enable[i] = 1'b0;
				next_prio[i]   = 3'h0;
			end
		end
		// Entry and return sequencing, fixed length for every source
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_pend_vec   = best.vector;
					next_pend_level = best.level;
					next_saved_ipl  = cpu_priority_level;
					next_ipl        = best.level;
					next_fetch_addr = best.addr;
					next_cnt        = ENTRY_CYCLES - 4'h1;
					next_state      = ST_ENTRY;
					for (int k = 0; k < NUM_TRAP; k++) begin
						if (best.vector == 7'(TRAP_VEC_FIRST + k)) next_trap_flag[k] = 1'b0;
					end
				end
			end
			ST_ENTRY: begin
				if (cnt == 4'h0) begin
					next_fetch_valid = 1'b1;
					next_stat[STAT_ENTRY] = 1'b1;
					next_state       = ST_SERVICE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			ST_SERVICE: begin
				if (cpu_return) begin
					next_cnt   = RETURN_CYCLES - 4'h1;
					next_state = ST_RETURN;
				end
			end
			ST_RETURN: begin
				if (cnt == 4'h0) begin
					next_ipl         = saved_ipl;
					next_return_done = 1'b1;
					next_stat[STAT_RETURN] = 1'b1;
					next_state       = ST_IDLE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_trap_flag = next_trap_flag | trap_req;
	end

	// Reset clears everything, puts the state in ST_IDLE and points the fetch address at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag        <= '0;
			enable      <= '0;
			prio        <= '0;
			trap_flag   <= '0;
			cpu_priority_level         <= IPL_RESET;
			saved_ipl   <= IPL_RESET;
			pend_vec    <= 7'h00;
			pend_level  <= 4'h0;
			stat        <= STAT_RESET;
			mask        <= STAT_RESET;
			state       <= ST_IDLE;
			cnt         <= 4'h0;
			fetch_valid <= 1'b0;
			fetch_addr  <= RESET_ADDR;
			return_done <= 1'b0;
		end else begin
			flag        <= next_flag;
			enable      <= next_enable;
			prio        <= next_prio;
			trap_flag   <= next_trap_flag;
			cpu_priority_level         <= next_ipl;
			saved_ipl   <= next_saved_ipl;
			pend_vec    <= next_pend_vec;
			pend_level  <= next_pend_level;
			stat        <= next_stat;
			mask        <= next_mask;
			state       <= next_state;
			cnt         <= next_cnt;
			fetch_valid <= next_fetch_valid;
			fetch_addr  <= next_fetch_addr;
			return_done <= next_return_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Single request line; held off while a sequence is in progress
	always_comb begin
		cpu_req       = best;
		cpu_req.valid = best.valid && (state == ST_IDLE);
	end

	assign irq = |(stat & mask);

endmodule
`default_nettype wire

// File: test/vic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire vic_pkg::vic_cpu_req_t cpu_req,
	input  wire logic                  fetch_valid,
	input  wire logic [3:0]            lag,
	output logic                       cpu_ack,
	output logic                       cpu_return
);
	import vic_pkg::*;
	int wait_n;
	int svc_n;
	// Handler time is long enough for software to clear its flag
	always @(posedge aclk) begin
		cpu_ack <= 1'b0;
		cpu_return <= 1'b0;
		wait_n = (aresetn && cpu_req.valid && !cpu_ack) ? wait_n + 1 : 0;
		if (wait_n > lag) begin
			cpu_ack <= 1'b1;
			wait_n = 0;
		end
		svc_n = !aresetn ? 0 : fetch_valid ? 24 : (svc_n > 0) ? svc_n - 1 : 0;
		if (svc_n == 1) cpu_return <= 1'b1;
	end
endmodule
`default_nettype wire

// File: test/vic_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module vic_top_sva (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [6:0]            trap_req,
	input  wire logic                  cpu_ack,
	input  wire logic                  cpu_return,
	input  wire vic_pkg::vic_cpu_req_t cpu_req,
	input  wire logic                  fetch_valid,
	input  wire logic [23:0]           fetch_addr,
	input  wire logic                  return_done
);
	import vic_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [23:0] taken;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			taken <= 24'h000000;
		else if (cpu_ack && cpu_req.valid)
			taken <= cpu_req.addr;
	end
	sequence s_take; cpu_ack && cpu_req.valid; endsequence
	// Fixed latency: one exact cycle count, no slack for any source
	sequence s_fetch; !fetch_valid ##4 fetch_valid; endsequence
	////////////////////////////////////////////////////////////////////////
	entry_latency_a: assert property (s_take |=> s_fetch)
		else $error("vector fetch not on time");
	entry_busy_a: assert property (s_take |=> !cpu_req.valid [*4])
		else $error("request offered during entry");
	fetch_pulse_a: assert property (fetch_valid |=> !fetch_valid)
		else $error("fetch pulse too long");
	fetch_addr_a: assert property (fetch_valid |-> fetch_addr == taken)
		else $error("fetch address differs from accepted entry");
	vector_map_a: assert property (
		cpu_req.valid |-> cpu_req.addr == TABLE_BASE + {16'h0000, cpu_req.vector, 1'b0})
		else $error("entry address wrong");
	zero_level_a: assert property (cpu_req.valid |-> cpu_req.level != 4'h0)
		else $error("level zero requested");
	trap_wins_a: assert property (
		$past(trap_req) != 7'h00 && cpu_req.valid |-> cpu_req.vector < 7'h08)
		else $error("trap lost arbitration");
	return_time_a: assert property ($rose(return_done) |-> $past(cpu_return, 4))
		else $error("return latency wrong");
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import vic_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, ext_irq_0 = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF, lag = 4'h0;
	logic [113:0] src_req = '0;
	logic [6:0] trap_req = 7'h00;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic cpu_ack, cpu_return, fetch_valid, return_done, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [23:0] fetch_addr, fq[$];
	logic [33:0] q[$];
	vic_cpu_req_t cpu_req;
	int n_errors = 0, comparisons = 0, w, ids[3] = '{0, 3, 11};
	logic [15:0] lfsr = 16'h001B;
	logic [2:0] p[3], pend;
	vic_top i_vic_top (.*);
	vic_cpu_model i_vic_cpu_model (.*);
	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY,
			input logic [3:0] s = 4'hF);
		q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic int pick(input logic [2:0] m);
		pick = 2;
		// Descending scan so ties go to the lower vector
		for (int i = 2; i >= 0; i--)
			if (m[i] && (!m[pick] || p[i] >= p[pick])) pick = i;
	endfunction
	task automatic wait_for(ref logic s);
		do @(posedge aclk); while (s !== 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", {s_axi_bresp, 32'h0}, q.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", {s_axi_rresp, s_axi_rdata}, q.pop_front());
		if (fetch_valid)
			chk("fetch", {10'h0, fetch_addr}, {10'h0, fq.pop_front()});
	end
	initial begin
		#300000;
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_PRIO, 34'h0);
		wr(12'hFFC, 32'h1, RESP_SLVERR);
		rd(12'hFFC, {RESP_SLVERR, 32'h0});
		wr(OFF_FLAG, 32'hFFFF);
		rd(OFF_FLAG, 34'h7FFF);
		wr(OFF_ENABLE + 12'h004, 32'hFFFF, RESP_OKAY, 4'h1);
		rd(OFF_ENABLE + 12'h004, 34'h001F);
		wr(OFF_FLAG, 32'h0);
		wr(OFF_ENABLE, 32'h0809);
		wr(OFF_IRQ_MASK, 32'h3);
		for (int r = 0; r < 4; r++) begin
			wr(OFF_CPU_IPL, 32'hF);
			rd(OFF_CPU_IPL, 34'h7);
			for (int i = 0; i < 3; i++) begin
				lfsr = lfsr_next(lfsr);
				p[i] = lfsr[2:0] | {2'b00, i != 0};
			end
			if (r == 0) p[2] = p[1];
			lag <= lfsr[7:4];
			wr(OFF_PRIO, {17'h0, p[1], 9'h000, p[0]});
			wr(OFF_PRIO + 12'h008, {17'h0, p[2], 12'h000});
			ext_irq_0 <= 1'b1;
			src_req[3] <= 1'b1;
			src_req[11] <= 1'b1;
			@(posedge aclk);
			src_req <= '0;
			repeat (4) @(posedge aclk);
			// Flags stay set long after the one-cycle source pulse
			rd(OFF_FLAG, 34'h0809);
			ext_irq_0 <= 1'b0;
			pend = {2'b11, p[0] != 3'h0};
			for (int k = 0; pend != 3'h0; k++) begin
				w = pick(pend);
				fq.push_back(TABLE_BASE + 24'(2 * (ids[w] + VEC_OFFSET)));
				if (k == 0) wr(OFF_CPU_IPL, 32'h0);
				wait_for(fetch_valid);
				rd(OFF_PENDING, {22'h0, 1'b0, p[w], 1'b0, 7'(ids[w] + VEC_OFFSET)});
				rd(OFF_CPU_IPL, {31'h0, p[w]});
				pend[w] = 1'b0;
				wr(OFF_FLAG, {20'h0, pend[2], 7'h00, pend[1], 2'b00, pend[0]});
				wait_for(return_done);
			end
			chk("irq", irq, 34'h1);
			wr(OFF_IRQ_MASK, 32'h0);
			chk("irq", irq, 34'h0);
			wr(OFF_IRQ_STATUS, 32'h3);
			rd(OFF_IRQ_STATUS, 34'h0);
			wr(OFF_IRQ_MASK, 32'h3);
		end
		wr(OFF_CPU_IPL, 32'h7);
		fq.push_back(TABLE_BASE + 24'h000006);
		trap_req[2] <= 1'b1;
		@(posedge aclk);
		trap_req <= 7'h00;
		wait_for(fetch_valid);
		rd(OFF_CPU_IPL, 34'hD);
		wait_for(return_done);
		rd(OFF_CPU_IPL, 34'h7);
		end_sim();
	end
endmodule
bind vic_top vic_top_sva i_vic_top_sva (.*);
`default_nettype wire
